/* rtl/fault_status_regs.sv */
/*
 Read/clear fault status registers for half-bridges: overcurrent 5-8, open load 1-4 and 5-8.
 Assumes a frame decoder presents each 16-bit command as a one-cycle strobe with its bytes,
 and fault detectors deliver one-cycle or level detection pulses synchronous to I_CLK.
*/
// Contract
// - The overcurrent register for bridges five to eight answers middle address bits 011 10, lowest bit one.
// - That register holds bridge 8 high/low in bits 7/6 down to bridge 5 high/low in bits 1/0.
// - An overcurrent detection sets and latches the switch's bit and turns that switch off.
// - All status bits reset to zero, meaning no error.
// - The open-load register for bridges one to four answers middle address bits 000 01, lowest bit one.
// - That register holds bridge 4 high/low in bits 7/6 down to bridge 1 high/low in bits 1/0.
// - An open-load detection sets and latches the switch's bit with no shutdown.
// - The open-load register for bridges five to eight answers middle address bits 100 01, lowest bit one.
// - That register holds bridge 8 high/low in bits 7/6 down to bridge 5 high/low in bits 1/0.
// - Address bit 7 zero reads the register, one clears it, within one two-byte command.
// - The bits are never cleared by the device itself, only by a clear command.
// - The global load-error flag is the OR of all status bits and falls when all are cleared.
`timescale 1ns/10ps
`default_nettype none
module fault_status_regs
	import fault_status_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_CMD_VALID,
	input  wire cmd_t        I_CMD,
	input  wire fault_t      I_FAULT,
	output logic      [7:0]  O_RD_DATA,
	output logic             O_RD_VALID,
	output logic             O_LOAD_ERR,
	output logic      [7:0]  O_OC_OFF_5_8
);
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	reg_sel_t   sel;
	logic       is_clear;
	logic [7:0] oc_r;
	logic [7:0] ol_lo_r;
	logic [7:0] ol_hi_r;
	logic [7:0] oc_nxt;
	logic [7:0] ol_lo_nxt;
	logic [7:0] ol_hi_nxt;
	logic       clr_oc;
	logic       clr_ol_lo;
	logic       clr_ol_hi;

	// Lab test bit and operation bit are don't-care for selection
	always_comb begin
		sel = SEL_NONE;
		if (I_CMD.addr[0] == ADDR_LSB_VAL) begin
			if (I_CMD.addr[6:2] == SEL_OC_5_8)
				sel = SEL_OC;
			else if (I_CMD.addr[6:2] == SEL_OL_1_4)
				sel = SEL_OL_LO;
			else if (I_CMD.addr[6:2] == SEL_OL_5_8)
				sel = SEL_OL_HI;
		end
	end

	assign is_clear  = I_CMD.addr[ADDR_OP_POS] == OP_CLEAR;
	assign clr_oc    = I_CMD_VALID && is_clear && (sel == SEL_OC);
	assign clr_ol_lo = I_CMD_VALID && is_clear && (sel == SEL_OL_LO);
	assign clr_ol_hi = I_CMD_VALID && is_clear && (sel == SEL_OL_HI);

	// ----------------------------------------------------------------
	// Latched flags
	// ----------------------------------------------------------------
	// A detection in the clear cycle wins so no event is lost
	always_comb begin
		oc_nxt    = (clr_oc ? STAT_RST : oc_r) | I_FAULT.oc_5_8;
		ol_lo_nxt = (clr_ol_lo ? STAT_RST : ol_lo_r) | I_FAULT.ol_1_4;
		ol_hi_nxt = (clr_ol_hi ? STAT_RST : ol_hi_r) | I_FAULT.ol_5_8;
	end

	// Only a clear command or I_SYS_RST removes a bit; no self-clearing path exists
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			oc_r    <= STAT_RST;
			ol_lo_r <= STAT_RST;
			ol_hi_r <= STAT_RST;
		end else begin
			oc_r    <= oc_nxt;
			ol_lo_r <= ol_lo_nxt;
			ol_hi_r <= ol_hi_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Shutdown follows the latched flag: the switch stays off until cleared
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_OC_OFF_5_8 <= STAT_RST;
			O_LOAD_ERR   <= 1'b0;
		end else begin
			O_OC_OFF_5_8 <= oc_nxt;
			O_LOAD_ERR   <= |{oc_nxt, ol_lo_nxt, ol_hi_nxt};
		end
	end

	// Read and clear both return the pre-clear content, all eight bits at once
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_RD_DATA  <= DATA_IDLE;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RD_VALID <= I_CMD_VALID && (sel != SEL_NONE);
			if (I_CMD_VALID) begin
				unique case (sel)
					SEL_OC:    O_RD_DATA <= oc_r;
					SEL_OL_LO: O_RD_DATA <= ol_lo_r;
					SEL_OL_HI: O_RD_DATA <= ol_hi_r;
					SEL_NONE:  O_RD_DATA <= DATA_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence clear_oc_s;
		I_CMD_VALID && I_CMD.addr == {OP_CLEAR, SEL_OC_5_8, 1'b0, ADDR_LSB_VAL};
	endsequence

	oc_latch_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_FAULT.oc_5_8[7] |=> oc_r[7] && O_OC_OFF_5_8[7])
		else $error("overcurrent bit 7 not latched");
	ol_latch_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_FAULT.ol_1_4[0] |=> ol_lo_r[0])
		else $error("open load bit 0 not latched");
	hold_flags_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		!clr_oc |=> (oc_r & $past(oc_r)) == $past(oc_r))
		else $error("overcurrent bit dropped without clear");
	oc_clear_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		clear_oc_s ##0 (I_FAULT.oc_5_8 == 8'h00) |=> oc_r == 8'h00)
		else $error("overcurrent clear failed");
	oc_decode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && I_CMD.addr == 8'h39 |=> O_RD_VALID && O_RD_DATA == $past(oc_r))
		else $error("overcurrent read decode wrong");
	ol_lo_decode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && I_CMD.addr == 8'h05 |=> O_RD_DATA == $past(ol_lo_r))
		else $error("open load 1-4 read decode wrong");
	ol_hi_decode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && I_CMD.addr == 8'h45 |=> O_RD_DATA == $past(ol_hi_r))
		else $error("open load 5-8 read decode wrong");
	load_err_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		##1 O_LOAD_ERR == |{oc_r, ol_lo_r, ol_hi_r})
		else $error("load error flag mismatch");
	reset_zero_a: assert property (@(posedge I_CLK)
		I_SYS_RST |=> oc_r == 8'h00 && ol_lo_r == 8'h00 && ol_hi_r == 8'h00)
		else $error("status not zero after reset");

	// ----------------------------------------------------------------
	// Further checks: clears, lab bit, refusal and bit layout
	// ----------------------------------------------------------------
	// Clear commands of the two open-load registers
	sequence clear_ol_lo_s;
		I_CMD_VALID && is_clear && (sel == SEL_OL_LO);
	endsequence

	sequence clear_ol_hi_s;
		I_CMD_VALID && is_clear && (sel == SEL_OL_HI);
	endsequence

	// A quiet clear empties the whole register
	ol_lo_clear_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		clear_ol_lo_s ##0 (I_FAULT.ol_1_4 == 8'h00) |=> ol_lo_r == 8'h00)
		else $error("open load 1-4 clear failed");

	ol_hi_clear_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		clear_ol_hi_s ##0 (I_FAULT.ol_5_8 == 8'h00) |=> ol_hi_r == 8'h00)
		else $error("open load 5-8 clear failed");

	// A detection landing with its clear must survive, or an event is lost
	set_wins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		clr_oc && I_FAULT.oc_5_8[0] |=> oc_r[0] && O_OC_OFF_5_8[0])
		else $error("overcurrent lost in clear cycle");

	// The lab test bit must not change which register answers
	lab_bit_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && I_CMD.addr == 8'h3B |=> O_RD_VALID && O_RD_DATA == $past(oc_r))
		else $error("lab bit changed decode");

	// Unmapped addresses get no valid strobe and an idle data byte
	unmapped_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && sel == SEL_NONE |=> !O_RD_VALID && O_RD_DATA == 8'h00)
		else $error("unmapped address answered");

	// A plain read must never remove an overcurrent flag
	read_keeps_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_CMD_VALID && !is_clear |=> oc_r == ($past(oc_r) | $past(I_FAULT.oc_5_8)))
		else $error("read altered overcurrent flags");

	// Switch-off tracks the latched flags one for one
	off_follows_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		##1 O_OC_OFF_5_8 == oc_r)
		else $error("switch-off differs from flags");

	// Bit layout at the far ends of each register
	oc_low_bit_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_FAULT.oc_5_8[0] |=> oc_r[0] && O_OC_OFF_5_8[0])
		else $error("overcurrent bit 0 not latched");

	ol_lo_top_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_FAULT.ol_1_4[7] |=> ol_lo_r[7])
		else $error("open load 1-4 bit 7 not latched");

	ol_hi_top_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		I_FAULT.ol_5_8[7] |=> ol_hi_r[7])
		else $error("open load 5-8 bit 7 not latched");

	// The valid strobe only ever answers a command one cycle back
	rd_valid_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_RD_VALID |-> $past(I_CMD_VALID))
		else $error("read valid without command");

	// Load error falls once every flag is gone
	load_err_low_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		##1 (oc_r == 8'h00 && ol_lo_r == 8'h00 && ol_hi_r == 8'h00) |-> !O_LOAD_ERR)
		else $error("load error stuck high");
endmodule
`default_nettype wire

/* rtl/fault_status_pkg.sv */
/*
 Constants and carrier types for the half-bridge fault status register bank.
 Assumes the serial frame decoder elsewhere delivers one decoded address/data command.
*/
package fault_status_pkg;
	// ----------------------------------------------------------------
	// Address byte layout
	// ----------------------------------------------------------------
	localparam int           ADDR_OP_POS   = 7;
	localparam int           ADDR_LAB_POS  = 1;
	localparam logic [4:0]   SEL_OC_5_8    = 5'h0E;
	localparam logic [4:0]   SEL_OL_1_4    = 5'h01;
	localparam logic [4:0]   SEL_OL_5_8    = 5'h11;
	localparam logic         ADDR_LSB_VAL  = 1'b1;
	localparam logic         OP_READ       = 1'b0;
	localparam logic         OP_CLEAR      = 1'b1;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]   STAT_RST      = 8'h00;
	localparam logic [7:0]   DATA_IDLE     = 8'h00;

	// One decoded command: address byte and data byte
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} cmd_t;

	// Fault inputs per switch: index 2k+1 high side, 2k low side
	typedef struct packed {
		logic [7:0] oc_5_8;
		logic [7:0] ol_1_4;
		logic [7:0] ol_5_8;
	} fault_t;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_OC,
		SEL_OL_LO,
		SEL_OL_HI
	} reg_sel_t;
endpackage

/* tb/mcu_model.sv */
/*
 Microcontroller model issuing decoded read and clear commands.
 Assumes the bench calls send() and samples the answer after it returns.
*/
`timescale 1ns/10ps
`default_nettype none
module mcu_model
	import fault_status_pkg::*;
(
	input  wire logic i_clk,
	output logic      o_valid,
	output cmd_t      o_cmd
);
	// Idle bus at time zero
	initial begin
		o_valid = 1'b0;
		o_cmd   = '0;
	end
	// One strobe per command; an idle edge follows so strobes never merge
	task automatic send(input logic [7:0] addr);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_cmd   <= '{addr: addr, data: ~addr};
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_cmd   <= '{addr: 8'hFF, data: 8'h5A}; // Junk after release, not the last value
	endtask
endmodule
`default_nettype wire

/* tb/test_half_bridge_fault_status_regs.sv */
/*
 Self-checking bench for the fault status register bank.
 Assumes the microcontroller model supplies commands; faults are driven here.
*/
`timescale 1ns/10ps
`default_nettype none
module test_half_bridge_fault_status_regs;
	import fault_status_pkg::*;
	typedef struct packed {
		fault_t     flt;
		logic [7:0] addr;
		logic [7:0] exp;
	} row_t;
	logic       I_CLK     = 1'b0;
	logic       I_SYS_RST = 1'b1;
	logic       cmd_valid;
	cmd_t       cmd;
	fault_t     fault = '0;
	logic [7:0] rd_data;
	logic [7:0] oc_off;
	logic       rd_valid;
	logic       load_err;
	int         bad_count   = 0;
	int         comparisons = 0;
	row_t       rows [4] = '{'{24'h800000, 8'h39, 8'h80}, '{24'h010000, 8'h39, 8'h01},
		'{24'h00C300, 8'h05, 8'hC3}, '{24'h00005A, 8'h45, 8'h5A}};
	// 25 MHz clock
	always #20 I_CLK = ~I_CLK;
	mcu_model mcu_model_i (.i_clk(I_CLK), .o_valid(cmd_valid), .o_cmd(cmd));
	fault_status_regs fault_status_regs_i (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
		.I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_FAULT(fault), .O_RD_DATA(rd_data),
		.O_RD_VALID(rd_valid), .O_LOAD_ERR(load_err), .O_OC_OFF_5_8(oc_off));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One-cycle detection pulse, as a detector would give it
	task automatic hit(input fault_t f);
		@(posedge I_CLK);
		fault <= f;
		@(posedge I_CLK);
		fault <= '0;
	endtask
	// Command, then look in the single cycle where the answer stands
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic v);
		mcu_model_i.send(a);
		#1;
		chk(rd_data, d);
		chk(rd_valid, v);
	endtask
	// Main sequence: table rows first, then the awkward cases
	initial begin
		repeat (8) @(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		#1 chk(oc_off, 8'h00);
		chk(load_err, 1'b0);
		foreach (rows[i]) acc(rows[i].addr, 8'h00, 1'b1);
		$display("reset values done");
		foreach (rows[i]) begin
			hit(rows[i].flt);
			acc(rows[i].addr, rows[i].exp, 1'b1);
			chk(load_err, 1'b1);
			chk(oc_off, rows[i].flt.oc_5_8);
			acc(rows[i].addr | 8'h80, rows[i].exp, 1'b1);
			chk(oc_off, 8'h00);
			chk(load_err, 1'b0);
			$display("row %0d done", i);
		end
		// Latching, then an unmapped clear must leave the flag alone
		hit(24'h000001);
		repeat (6) @(posedge I_CLK);
		acc(8'h45, 8'h01, 1'b1);
		acc(8'h99, 8'h00, 1'b0);
		acc(8'h45, 8'h01, 1'b1);
		$display("latch and unmapped done");
		@(posedge I_CLK);
		I_SYS_RST <= 1'b1;
		repeat (2) @(posedge I_CLK);
		I_SYS_RST <= 1'b0;
		acc(8'h45, 8'h00, 1'b1);
		chk(load_err, 1'b0);
		$display("mid-run reset done");
		// Detection in the clear cycle wins; lab test bit set on both accesses
		fork
			hit(24'h000002);
			mcu_model_i.send(8'hC7);
		join
		#1 chk(rd_data, 8'h00);
		acc(8'h47, 8'h02, 1'b1);
		chk(load_err, 1'b1);
		$display("clear collision done");
		finish_test;
	end
	// Watchdog far beyond the roughly 63 cycles the sequence needs
	initial begin
		repeat (400) @(posedge I_CLK);
		bad_count++;
		finish_test;
	end
endmodule
`default_nettype wire
